// file: rtl/pmbus_cmd_pkg.sv
package pmbus_cmd_pkg;

  // ======================================================
  // Command codes
  localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
  localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_VOUT_READ = 8'h8b;
  localparam logic [7:0] CMD_IOUT_READ = 8'h8c;
  localparam logic [7:0] CMD_TEMP_READ = 8'h8d;
  localparam logic [7:0] CMD_PROTO_REV = 8'h98;
  localparam logic [7:0] CMD_DEV_CODE = 8'had;
  localparam logic [7:0] CMD_DEV_REV = 8'hae;
  localparam logic [7:0] CMD_SCRATCH = 8'hd0;
  localparam logic [7:0] CMD_REF_TRIM = 8'hd4;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'hd5;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'hd6;
  localparam logic [7:0] CMD_LIMIT_PCT = 8'hd7;
  localparam logic [7:0] CMD_USER_OPT = 8'he5;
  localparam logic [7:0] CMD_MISC_OPT = 8'hf0;

  // ======================================================
  // Reset and restore values
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [15:0] USER_OPT_RST = 16'h0084;
  localparam logic [15:0] MISC_OPT_RST = 16'h0013;
  localparam logic [15:0] HIGH_STEP_OPT0 = 16'h0009;
  localparam logic [15:0] HIGH_STEP_OPT1 = 16'h000f;
  localparam logic [15:0] LOW_STEP_OPT0 = 16'hfff7;
  localparam logic [15:0] LOW_STEP_OPT1 = 16'hfff1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ======================================================
  // Framing
  localparam int BYTE_W = 8;
  localparam logic [7:0] BLOCK_COUNT = 8'h02;
  localparam logic [1:0] IDX_FIRST = 2'h0;
  localparam logic [1:0] IDX_SECOND = 2'h1;
  localparam logic [1:0] IDX_THIRD = 2'h2;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;
  localparam int COMM_BAD_CMD = 7;
  localparam int COMM_BAD_DATA = 6;
  localparam logic [1:0] RESTORE_WAIT = 2'h3;
  localparam logic [1:0] RESTORE_LAST = 2'h1;
  localparam logic [1:0] RESTORE_DONE = 2'h0;

  // ======================================================
  // Types
  typedef enum logic [2:0] {
    KIND_NONE, KIND_RO_BYTE, KIND_RO_WORD, KIND_RO_BLOCK, KIND_RW_BYTE, KIND_RW_WORD
  } cmd_kind_t;

  typedef enum logic [1:0] {MARGIN_OFF, MARGIN_LOW, MARGIN_HIGH, MARGIN_BAD} margin_sel_t;

  typedef struct packed {
    logic [7:0] code;
    logic write;
    logic [1:0] byte_idx;
    logic [1:0] wr_len;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic ack;
    logic last;
  } cmd_rsp_t;

  typedef struct packed {
    logic [15:0] ref_trim;
    logic [15:0] margin_high;
    logic [15:0] margin_low;
    logic [7:0] limit_pct;
    logic [15:0] user_opt;
    logic [15:0] misc_opt;
  } cfg_t;

  // ======================================================
  // Functions
  function automatic cmd_kind_t kind_of(input logic [7:0] code);
    case (code)
      CMD_TEMP_STATUS, CMD_COMM_STATUS, CMD_VENDOR_STATUS, CMD_PROTO_REV: kind_of = KIND_RO_BYTE;
      CMD_VOUT_READ, CMD_IOUT_READ, CMD_TEMP_READ: kind_of = KIND_RO_WORD;
      CMD_DEV_CODE, CMD_DEV_REV: kind_of = KIND_RO_BLOCK;
      CMD_LIMIT_PCT: kind_of = KIND_RW_BYTE;
      CMD_SCRATCH, CMD_REF_TRIM, CMD_MARGIN_HIGH, CMD_MARGIN_LOW,
      CMD_USER_OPT, CMD_MISC_OPT: kind_of = KIND_RW_WORD;
      default: kind_of = KIND_NONE;
    endcase
  endfunction

  // Two's complement wrap is intended; offsets may be negative
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    add16 = s[15:0];
  endfunction

endpackage

// file: rtl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // bit_sync

// file: rtl/read_byte_select.sv
`timescale 1ns/1ps
module read_byte_select (
  input wire pmbus_cmd_pkg::cmd_kind_t kind,
  input wire logic [1:0] idx,
  input wire logic [15:0] value,
  output logic [7:0] data,
  output logic ok,
  output logic last
);
  localparam int BW = pmbus_cmd_pkg::BYTE_W;

  always_comb begin
    data = pmbus_cmd_pkg::BYTE_ZERO;
    ok = 1'b0;
    last = 1'b1;
    unique case (kind)
      pmbus_cmd_pkg::KIND_RO_BYTE, pmbus_cmd_pkg::KIND_RW_BYTE: begin
        ok = (idx == pmbus_cmd_pkg::IDX_FIRST);
        data = value[BW-1:0];
      end
      pmbus_cmd_pkg::KIND_RO_WORD, pmbus_cmd_pkg::KIND_RW_WORD: begin
        // Low byte first, then high byte
        ok = (idx == pmbus_cmd_pkg::IDX_FIRST) || (idx == pmbus_cmd_pkg::IDX_SECOND);
        last = (idx == pmbus_cmd_pkg::IDX_SECOND);
        data = (idx == pmbus_cmd_pkg::IDX_FIRST) ? value[BW-1:0] : value[2*BW-1:BW];
      end
      pmbus_cmd_pkg::KIND_RO_BLOCK: begin
        ok = (idx != 2'h3);
        last = (idx == pmbus_cmd_pkg::IDX_THIRD);
        if (idx == pmbus_cmd_pkg::IDX_FIRST) begin
          data = pmbus_cmd_pkg::BLOCK_COUNT;
        end else if (idx == pmbus_cmd_pkg::IDX_SECOND) begin
          data = value[BW-1:0];
        end else begin
          data = value[2*BW-1:BW];
        end
      end
      pmbus_cmd_pkg::KIND_NONE: begin
        ok = 1'b0;
      end
    endcase
  end
endmodule // read_byte_select

// file: rtl/pmbus_status_telemetry_cmds.sv
`timescale 1ns/1ps
// Function
// - Code 7Dh returns one temperature fault and warning status byte
// - Code 7Eh returns one serial communication fault status byte
// - Code 80h returns internal overtemperature and address-detect fault byte
// - Code 8Bh returns measured output voltage, read only
// - Code 8Ch returns measured output current, read only
// - Code 8Dh returns measured die temperature, read only
// - Code 98h returns a fixed protocol revision byte
// - Code ADh block read: count 2, device code low then high
// - Code AEh block read: count 2, revision low then high
// - Code D4h offsets error amp reference, default zero
// - Code D5h raises reference; restore value chosen by high-step pin
// - Code D6h lowers reference; restore value chosen by low-step pin
// - Code D7h sets good, under and over voltage limit percentages, default 00h
// - Code E5h user options, default 0084h
// - Code F0h miscellaneous options, default 0013h
// - Writes to read-only commands are discarded, contents unchanged
module pmbus_status_telemetry_cmds #(
  // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5a01,
  // Arbitrary value
  parameter logic [15:0] DEVICE_REV = 16'h0102,
  // Arbitrary value
  parameter logic [7:0] PROTO_REV = 8'h11
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire pmbus_cmd_pkg::cmd_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output pmbus_cmd_pkg::cmd_rsp_t rsp,
  input wire logic [7:0] comm_fault_event,
  input wire logic clear_faults,
  input wire logic [7:0] temp_status_in,
  input wire logic [7:0] vendor_status_in,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] iout_meas,
  input wire logic [15:0] temp_meas,
  input wire logic high_step_pin_option,
  input wire logic low_step_pin_option,
  input wire logic [15:0] nominal_ref,
  input wire pmbus_cmd_pkg::margin_sel_t margin_sel,
  output pmbus_cmd_pkg::cfg_t cfg,
  output logic [15:0] error_amp_reference
);

  // ======================================================
  // Pin options and restore sequence
  logic [1:0] pin_sync;
  logic high_opt;
  logic low_opt;
  logic [1:0] restore_cnt_ff;
  logic restoring;
  logic restore_load;

  bit_sync #(.W(2)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({high_step_pin_option, low_step_pin_option}),
    .q(pin_sync)
  );

  assign high_opt = pin_sync[1];
  assign low_opt = pin_sync[0];

  // Straps are caught only after the synchroniser has settled past reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      restore_cnt_ff <= pmbus_cmd_pkg::RESTORE_WAIT;
    end else if (restore_cnt_ff != pmbus_cmd_pkg::RESTORE_DONE) begin
      restore_cnt_ff <= restore_cnt_ff - pmbus_cmd_pkg::RESTORE_LAST;
    end
  end

  assign restoring = (restore_cnt_ff != pmbus_cmd_pkg::RESTORE_DONE);
  assign restore_load = (restore_cnt_ff == pmbus_cmd_pkg::RESTORE_LAST);

  // ======================================================
  // Request decode
  pmbus_cmd_pkg::cmd_kind_t kind;
  logic take;
  logic rd_take;
  logic wr_take;
  logic kind_ro;
  logic kind_rw;
  logic len_ok;
  logic wr_accept;
  logic bad_cmd;
  logic bad_data;

  // Stalled during restore so no write races the strap load
  assign req_ready = ~restoring;
  assign take = req_valid & req_ready;
  assign kind = pmbus_cmd_pkg::kind_of(req.code);
  assign rd_take = take & ~req.write;
  assign wr_take = take & req.write;
  assign kind_ro = (kind == pmbus_cmd_pkg::KIND_RO_BYTE) || (kind == pmbus_cmd_pkg::KIND_RO_WORD)
                   || (kind == pmbus_cmd_pkg::KIND_RO_BLOCK);
  assign kind_rw = (kind == pmbus_cmd_pkg::KIND_RW_BYTE) || (kind == pmbus_cmd_pkg::KIND_RW_WORD);
  assign len_ok = ((kind == pmbus_cmd_pkg::KIND_RW_BYTE) && (req.wr_len == pmbus_cmd_pkg::LEN_BYTE))
                  || ((kind == pmbus_cmd_pkg::KIND_RW_WORD) && (req.wr_len == pmbus_cmd_pkg::LEN_WORD));
  assign wr_accept = wr_take & kind_rw & len_ok;
  assign bad_cmd = take & ((kind == pmbus_cmd_pkg::KIND_NONE) | (req.write & kind_ro));
  assign bad_data = wr_take & kind_rw & ~len_ok;

  function automatic logic wr_hit(input logic [7:0] code, input logic [7:0] target,
                                  input logic accept);
    wr_hit = accept && (code == target);
  endfunction

  // ======================================================
  // Writable registers
  logic [15:0] scratch_ff;
  logic [15:0] trim_ff;
  logic [15:0] high_step_ff;
  logic [15:0] low_step_ff;
  logic [7:0] limit_ff;
  logic [15:0] user_opt_ff;
  logic [15:0] misc_opt_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scratch_ff <= pmbus_cmd_pkg::SCRATCH_RST;
    end else if (wr_hit(req.code, pmbus_cmd_pkg::CMD_SCRATCH, wr_accept)) begin
      scratch_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trim_ff <= pmbus_cmd_pkg::TRIM_RST;
    end else if (wr_hit(req.code, pmbus_cmd_pkg::CMD_REF_TRIM, wr_accept)) begin
      trim_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      high_step_ff <= pmbus_cmd_pkg::HIGH_STEP_OPT0;
    end else if (restore_load) begin
      high_step_ff <= high_opt ? pmbus_cmd_pkg::HIGH_STEP_OPT1 : pmbus_cmd_pkg::HIGH_STEP_OPT0;
    end else if (wr_hit(req.code, pmbus_cmd_pkg::CMD_MARGIN_HIGH, wr_accept)) begin
      high_step_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_step_ff <= pmbus_cmd_pkg::LOW_STEP_OPT0;
    end else if (restore_load) begin
      low_step_ff <= low_opt ? pmbus_cmd_pkg::LOW_STEP_OPT1 : pmbus_cmd_pkg::LOW_STEP_OPT0;
    end else if (wr_hit(req.code, pmbus_cmd_pkg::CMD_MARGIN_LOW, wr_accept)) begin
      low_step_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      limit_ff <= pmbus_cmd_pkg::LIMIT_RST;
    end else if (wr_hit(req.code, pmbus_cmd_pkg::CMD_LIMIT_PCT, wr_accept)) begin
      limit_ff <= req.wdata[pmbus_cmd_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      user_opt_ff <= pmbus_cmd_pkg::USER_OPT_RST;
      misc_opt_ff <= pmbus_cmd_pkg::MISC_OPT_RST;
    end else begin
      if (wr_hit(req.code, pmbus_cmd_pkg::CMD_USER_OPT, wr_accept)) begin
        user_opt_ff <= req.wdata;
      end
      if (wr_hit(req.code, pmbus_cmd_pkg::CMD_MISC_OPT, wr_accept)) begin
        misc_opt_ff <= req.wdata;
      end
    end
  end

  assign cfg = '{ref_trim: trim_ff, margin_high: high_step_ff, margin_low: low_step_ff,
                 limit_pct: limit_ff, user_opt: user_opt_ff, misc_opt: misc_opt_ff};

  // ======================================================
  // Error amp reference
  logic [15:0] step_sel;
  logic [15:0] ref_sum;
  logic [15:0] err_ref_ff;

  // Low step is stored negative, so both margins add
  always_comb begin
    step_sel = pmbus_cmd_pkg::WORD_ZERO;
    unique case (margin_sel)
      pmbus_cmd_pkg::MARGIN_HIGH: step_sel = high_step_ff;
      pmbus_cmd_pkg::MARGIN_LOW: step_sel = low_step_ff;
      pmbus_cmd_pkg::MARGIN_OFF, pmbus_cmd_pkg::MARGIN_BAD: step_sel = pmbus_cmd_pkg::WORD_ZERO;
    endcase
  end

  assign ref_sum = pmbus_cmd_pkg::add16(pmbus_cmd_pkg::add16(nominal_ref, trim_ff), step_sel);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_ref_ff <= pmbus_cmd_pkg::WORD_ZERO;
    end else begin
      err_ref_ff <= ref_sum;
    end
  end

  assign error_amp_reference = err_ref_ff;

  // ======================================================
  // Communication fault status
  logic [7:0] comm_ff;
  logic [7:0] comm_set;

  always_comb begin
    comm_set = comm_fault_event;
    comm_set[pmbus_cmd_pkg::COMM_BAD_CMD] = comm_fault_event[pmbus_cmd_pkg::COMM_BAD_CMD] | bad_cmd;
    comm_set[pmbus_cmd_pkg::COMM_BAD_DATA] = comm_fault_event[pmbus_cmd_pkg::COMM_BAD_DATA]
                                             | bad_data;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comm_ff <= pmbus_cmd_pkg::STATUS_RST;
    end else begin
      comm_ff <= (clear_faults ? pmbus_cmd_pkg::STATUS_RST : comm_ff) | comm_set;
    end
  end

  // ======================================================
  // Read path
  logic [15:0] cur_value;
  logic [15:0] snap_ff;
  logic [15:0] sel_value;
  logic [7:0] sel_data;
  logic sel_ok;
  logic sel_last;
  logic rsp_valid_ff;
  pmbus_cmd_pkg::cmd_rsp_t rsp_ff;

  always_comb begin
    cur_value = pmbus_cmd_pkg::WORD_ZERO;
    case (req.code)
      pmbus_cmd_pkg::CMD_TEMP_STATUS: cur_value = {pmbus_cmd_pkg::BYTE_ZERO, temp_status_in};
      pmbus_cmd_pkg::CMD_COMM_STATUS: cur_value = {pmbus_cmd_pkg::BYTE_ZERO, comm_ff};
      pmbus_cmd_pkg::CMD_VENDOR_STATUS: cur_value = {pmbus_cmd_pkg::BYTE_ZERO, vendor_status_in};
      pmbus_cmd_pkg::CMD_VOUT_READ: cur_value = vout_meas;
      pmbus_cmd_pkg::CMD_IOUT_READ: cur_value = iout_meas;
      pmbus_cmd_pkg::CMD_TEMP_READ: cur_value = temp_meas;
      pmbus_cmd_pkg::CMD_PROTO_REV: cur_value = {pmbus_cmd_pkg::BYTE_ZERO, PROTO_REV};
      pmbus_cmd_pkg::CMD_DEV_CODE: cur_value = DEVICE_CODE;
      pmbus_cmd_pkg::CMD_DEV_REV: cur_value = DEVICE_REV;
      pmbus_cmd_pkg::CMD_SCRATCH: cur_value = scratch_ff;
      pmbus_cmd_pkg::CMD_REF_TRIM: cur_value = trim_ff;
      pmbus_cmd_pkg::CMD_MARGIN_HIGH: cur_value = high_step_ff;
      pmbus_cmd_pkg::CMD_MARGIN_LOW: cur_value = low_step_ff;
      pmbus_cmd_pkg::CMD_LIMIT_PCT: cur_value = {pmbus_cmd_pkg::BYTE_ZERO, limit_ff};
      pmbus_cmd_pkg::CMD_USER_OPT: cur_value = user_opt_ff;
      pmbus_cmd_pkg::CMD_MISC_OPT: cur_value = misc_opt_ff;
      default: cur_value = pmbus_cmd_pkg::WORD_ZERO;
    endcase
  end

  // Snapshot on the first byte so a live reading cannot tear between bytes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snap_ff <= pmbus_cmd_pkg::WORD_ZERO;
    end else if (rd_take && (req.byte_idx == pmbus_cmd_pkg::IDX_FIRST)) begin
      snap_ff <= cur_value;
    end
  end

  assign sel_value = (req.byte_idx == pmbus_cmd_pkg::IDX_FIRST) ? cur_value : snap_ff;

  read_byte_select u_sel (
    .kind(kind),
    .idx(req.byte_idx),
    .value(sel_value),
    .data(sel_data),
    .ok(sel_ok),
    .last(sel_last)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= take;
      if (rd_take) begin
        rsp_ff <= '{data: sel_data, ack: sel_ok, last: sel_last};
      end else if (wr_take) begin
        // Refused write answered with no acknowledge
        rsp_ff <= '{data: pmbus_cmd_pkg::BYTE_ZERO, ack: wr_accept, last: 1'b1};
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;

  // ======================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic rd_first;
  logic [15:0] wdata_w;
  assign rd_first = rd_take && (req.byte_idx == pmbus_cmd_pkg::IDX_FIRST);
  assign wdata_w = req.wdata;

  temp_status_a: assert property (rd_first && req.code == pmbus_cmd_pkg::CMD_TEMP_STATUS
    |=> rsp_valid && rsp.ack && rsp.last && rsp.data == $past(temp_status_in))
    else $error("temperature status byte wrong");
  comm_sticky_a: assert property (comm_set != pmbus_cmd_pkg::STATUS_RST
    |=> (comm_ff & $past(comm_set)) == $past(comm_set))
    else $error("communication fault bit lost");
  vendor_status_a: assert property (rd_first && req.code == pmbus_cmd_pkg::CMD_VENDOR_STATUS
    |=> rsp.ack && rsp.data == $past(vendor_status_in))
    else $error("vendor status byte wrong");
  vout_low_a: assert property (rd_first && req.code == pmbus_cmd_pkg::CMD_VOUT_READ
    |=> rsp.ack && !rsp.last && rsp.data == $past(vout_meas[7:0]))
    else $error("voltage low byte wrong");
  ro_write_nack_a: assert property (wr_take && kind_ro
    |=> rsp_valid && !rsp.ack && $stable(cfg) && $stable(scratch_ff))
    else $error("read-only write not refused");
  proto_rev_a: assert property (rd_first && req.code == pmbus_cmd_pkg::CMD_PROTO_REV
    |=> rsp.data == PROTO_REV && rsp.last)
    else $error("protocol revision wrong");
  block_count_a: assert property (rd_first && req.code == pmbus_cmd_pkg::CMD_DEV_CODE
    |=> rsp.data == pmbus_cmd_pkg::BLOCK_COUNT && !rsp.last && rsp.ack)
    else $error("block count wrong");
  rev_high_a: assert property (rd_take && req.code == pmbus_cmd_pkg::CMD_DEV_REV
    && req.byte_idx == pmbus_cmd_pkg::IDX_THIRD |=> rsp.data == DEVICE_REV[15:8] && rsp.last)
    else $error("revision high byte wrong");
  ref_sum_a: assert property (margin_sel == pmbus_cmd_pkg::MARGIN_OFF
    |=> error_amp_reference == 16'($past(nominal_ref) + $past(cfg.ref_trim)))
    else $error("reference not offset");
  high_restore_a: assert property (restore_load |=> high_step_ff ==
    ($past(high_opt) ? pmbus_cmd_pkg::HIGH_STEP_OPT1 : pmbus_cmd_pkg::HIGH_STEP_OPT0))
    else $error("high step restore wrong");
  scratch_echo_a: assert property (wr_hit(req.code, pmbus_cmd_pkg::CMD_SCRATCH, wr_accept)
    |=> scratch_ff == $past(wdata_w) && rsp_valid && rsp.ack)
    else $error("scratch pad not echoed");

  block_read_c: cover property (rd_first && req.code == pmbus_cmd_pkg::CMD_DEV_CODE);
  refused_write_c: cover property (wr_take && kind_ro);
  margin_high_c: cover property (margin_sel == pmbus_cmd_pkg::MARGIN_HIGH && !restoring);

endmodule // pmbus_status_telemetry_cmds

// file: test/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model (
  input wire logic sys_clk,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire pmbus_cmd_pkg::cmd_rsp_t rsp,
  output logic req_valid,
  output pmbus_cmd_pkg::cmd_req_t req
);
  // ====
  // Host requests
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic xfer(input logic [7:0] c, input logic w, input logic [1:0] i,
      input logic [1:0] n, input logic [15:0] d, output pmbus_cmd_pkg::cmd_rsp_t r,
      output logic v);
    int k;
    k = 0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = {c, w, i, n, d};
    while (!req_ready && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    r = rsp;
    v = rsp_valid;
    req_valid = 1'b0;
    // Released bus shows the inverse, never a stale request
    req = ~req;
  endtask
endmodule // pmbus_host_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst, req_valid, req_ready, rsp_valid, clear_faults, hi_pin, lo_pin, v;
  pmbus_cmd_pkg::cmd_req_t req;
  pmbus_cmd_pkg::cmd_rsp_t rsp, r;
  pmbus_cmd_pkg::cfg_t cfg;
  pmbus_cmd_pkg::margin_sel_t msel;
  logic [7:0] cfe, tsi, vsi;
  logic [15:0] vo, io, tm, nref, ear, w, trim, hs, ls;
  int err_total, n_tests;
  localparam logic [15:0] DEV_C = 16'h3c5e; // Arbitrary value
  localparam logic [15:0] DEV_R = 16'h0a07; // Arbitrary value
  localparam logic [7:0] PREV = 8'h2b; // Arbitrary value
  pmbus_status_telemetry_cmds #(.DEVICE_CODE(DEV_C), .DEVICE_REV(DEV_R), .PROTO_REV(PREV))
    dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .comm_fault_event(cfe),
    .clear_faults(clear_faults), .temp_status_in(tsi), .vendor_status_in(vsi),
    .vout_meas(vo), .iout_meas(io), .temp_meas(tm), .high_step_pin_option(hi_pin),
    .low_step_pin_option(lo_pin), .nominal_ref(nref), .margin_sel(msel), .cfg(cfg),
    .error_amp_reference(ear));
  pmbus_host_model host_u (.sys_clk(sys_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .req_valid(req_valid), .req(req));
  // ====
  // Compare and bus helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [1:0] i, input logic [7:0] d,
      input logic l);
    host_u.xfer(c, 1'b0, i, 2'h0, 16'h0, r, v);
    chk("rsp", {5'h0, 1'b1, d, 1'b1, l}, {5'h0, v, r.data, r.ack, r.last});
  endtask
  task automatic rdw(input logic [7:0] c, input logic [15:0] e);
    rd(c, 2'h0, e[7:0], 1'b0);
    rd(c, 2'h1, e[15:8], 1'b1);
  endtask
  task automatic wr(input logic [7:0] c, input logic [1:0] n, input logic [15:0] d,
      input logic a);
    host_u.xfer(c, 1'b1, 2'h0, n, d, r, v);
    chk("wr_ack", {14'h0, 1'b1, a}, {14'h0, v, r.ack});
  endtask
  task automatic blk(input logic [7:0] c, input logic [15:0] e);
    rd(c, 2'h0, 8'h02, 1'b0);
    rd(c, 2'h1, e[7:0], 1'b0);
    rd(c, 2'h2, e[15:8], 1'b1);
  endtask
  task automatic clr;
    @(negedge sys_clk) clear_faults = 1'b1;
    @(negedge sys_clk) clear_faults = 1'b0;
  endtask
  function automatic logic [15:0] ref_exp(input logic [15:0] n, t, h, l,
      input pmbus_cmd_pkg::margin_sel_t s);
    case (s)
      pmbus_cmd_pkg::MARGIN_HIGH: return n + t + h;
      pmbus_cmd_pkg::MARGIN_LOW: return n + t + l;
      default: return n + t;
    endcase
  endfunction
  task automatic print_verdict;
    $display("Checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Generous bound; the sequence needs a few hundred cycles
  initial begin
    repeat (50000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  // ====
  // Main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h387f58c5));
    {rst, clear_faults, cfe, tsi, vsi, vo, io, tm} = {1'b1, 73'h0};
    msel = pmbus_cmd_pkg::MARGIN_OFF;
    nref = 16'h0100;
    hi_pin = 1'($urandom);
    lo_pin = 1'($urandom);
    repeat (12) @(posedge sys_clk);
    chk("ready_rst", 16'h0, {15'h0, req_ready});
    @(negedge sys_clk) rst = 1'b0;
    hs = hi_pin ? pmbus_cmd_pkg::HIGH_STEP_OPT1 : pmbus_cmd_pkg::HIGH_STEP_OPT0;
    ls = lo_pin ? pmbus_cmd_pkg::LOW_STEP_OPT1 : pmbus_cmd_pkg::LOW_STEP_OPT0;
    rdw(8'hd4, 16'h0000);
    rdw(8'hd5, hs);
    rdw(8'hd6, ls);
    rd(8'hd7, 2'h0, 8'h00, 1'b1);
    rdw(8'he5, 16'h0084);
    rdw(8'hf0, 16'h0013);
    rdw(8'hd0, 16'h0000);
    rd(8'h98, 2'h0, PREV, 1'b1);
    blk(8'had, DEV_C);
    blk(8'hae, DEV_R);
    repeat (6) begin
      {tsi, vsi, vo} = 32'($urandom);
      {io, tm} = 32'($urandom);
      rd(8'h7d, 2'h0, tsi, 1'b1);
      rd(8'h80, 2'h0, vsi, 1'b1);
      rdw(8'h8b, vo);
      rdw(8'h8c, io);
      rdw(8'h8d, tm);
    end
    clr();
    rd(8'h7e, 2'h0, 8'h00, 1'b1);
    wr(8'h8b, 2'h2, ~vo, 1'b0);
    wr(8'h42, 2'h2, 16'h1234, 1'b0);
    rdw(8'h8b, vo);
    wr(8'hd7, 2'h2, 16'h00ff, 1'b0);
    rd(8'h7e, 2'h0, 8'hc0, 1'b1);
    rd(8'hd7, 2'h0, 8'h00, 1'b1);
    clr();
    @(negedge sys_clk) cfe = 8'h05;
    @(negedge sys_clk) cfe = 8'h00;
    rd(8'h7e, 2'h0, 8'h05, 1'b1);
    repeat (12) begin
      {trim, hs} = 32'($urandom);
      {ls, w} = 32'($urandom);
      wr(8'hd4, 2'h2, trim, 1'b1);
      wr(8'hd5, 2'h2, hs, 1'b1);
      wr(8'hd6, 2'h2, ls, 1'b1);
      wr(8'hd0, 2'h2, w, 1'b1);
      rdw(8'hd0, w);
      wr(8'hd7, 2'h1, ~w, 1'b1);
      rd(8'hd7, 2'h0, ~w[7:0], 1'b1);
      wr(8'he5, 2'h2, w, 1'b1);
      rdw(8'he5, w);
      wr(8'hf0, 2'h2, ~w, 1'b1);
      rdw(8'hf0, ~w);
      chk("cfg_trim", trim, cfg.ref_trim);
      @(negedge sys_clk);
      nref = 16'($urandom);
      msel = pmbus_cmd_pkg::margin_sel_t'(2'($urandom));
      repeat (2) @(negedge sys_clk);
      chk("ear", ref_exp(nref, trim, hs, ls, msel), ear);
    end
    @(negedge sys_clk) rst = 1'b1;
    hi_pin = ~hi_pin;
    lo_pin = ~lo_pin;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    hs = hi_pin ? pmbus_cmd_pkg::HIGH_STEP_OPT1 : pmbus_cmd_pkg::HIGH_STEP_OPT0;
    ls = lo_pin ? pmbus_cmd_pkg::LOW_STEP_OPT1 : pmbus_cmd_pkg::LOW_STEP_OPT0;
    rdw(8'hd4, 16'h0000);
    rdw(8'hd5, hs);
    rdw(8'hd6, ls);
    rdw(8'hd0, 16'h0000);
    rdw(8'he5, 16'h0084);
    print_verdict();
  end
endmodule // testbench
